// ### src/clsr_exec.v
// Purpose: Executes loads, status loads/presets, no-op, port reads and returns
// Assumes: Instruction bytes are offered by the fetch logic with i_ins_valid
// Notes:   Bus inputs come from pins and pass two flip-flops before use
//
// Summary of operation
// - Absolute load: three bytes, memory byte into register, four cycles.
// - Indexed absolute load: low opcode bits pick index, destination is register zero.
// - Loads and port reads set condition code: 01 positive, 00 zero, 10 negative.
// - Immediate load: second byte into register, two cycles.
// - Relative load: address is next-instruction address plus displacement, three cycles.
// - Load to register zero copies the register; source unchanged; 00 undefined.
// - Low status load takes register zero whole; condition code from bits 7,6.
// - High status load takes register zero; bits 4 and 3 forced zero.
// - No-operation changes nothing and still takes two cycles.
// - Low status preset sets masked bits, keeps others, three cycles.
// - High status preset sets masked bits except 4 and 3, keeps others, three cycles.
// - Control read: request, IO, read, control, non-extended; byte within two cycles.
// - Data read: request, IO, read, data, non-extended; device drives bus.
// - Port reads store high bus lines as ones.
// - Extended read puts second byte on address bus, request, IO, read, extended.
// - Conditional return on field match pops return stack, decrements stack pointer.
// - Field value three makes both returns unconditional.
// - Enabling return clears interrupt inhibit only when return is taken.
// - Accepted interrupt branches to subroutine and sets interrupt inhibit.
`timescale 1ns/1ns
`default_nettype none
`include "clsr_defs.vh"

module clsr_exec (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_ins_valid,
    input  wire [7:0]  i_ins_byte0,
    input  wire [7:0]  i_ins_byte1,
    input  wire [7:0]  i_ins_byte2,
    input  wire [14:0] i_ins_addr,
    input  wire        i_int_req,
    input  wire [14:0] i_int_vector,
    input  wire [7:0]  i_data_bus,
    output reg         o_busy,
    output reg         o_operation_request,
    output reg         o_mem_io_n,
    output reg         o_read_n_write,
    output reg         o_data_n_ctrl,
    output reg         o_extended_select,
    output reg  [14:0] o_addr_bus,
    output reg  [14:0] o_instruction_address_register,
    output reg  [7:0]  o_status_low_byte,
    output reg  [7:0]  o_status_high_byte,
    output reg  [7:0]  o_reg0,
    output reg  [7:0]  o_reg1,
    output reg  [7:0]  o_reg2,
    output reg  [7:0]  o_reg3
);
    localparam S_IDLE = 2'h0;
    localparam S_BUS  = 2'h1;
    localparam S_WAIT = 2'h2;

    wire       cyc_end;
    reg  [1:0] state_q;
    reg  [2:0] cyc_q;
    reg  [7:0] bus_m_q;
    reg  [7:0] bus_s_q;
    reg  [7:0] b0_q;
    reg  [7:0] b1_q;
    reg  [14:0] next_q;
    reg  [14:0] ras_q [0:7];
    reg  [7:0] gpr [0:3];
    reg  [7:0] ld_val;
    reg  [1:0] dst;
    reg  [1:0] cc_new;
    reg  [2:0] sp_dec;
    reg  [2:0] sp_inc;
    reg  [14:0] ind_addr;
    reg  [14:0] rel_addr;
    integer    k;

    clsr_phase u_phase (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .o_cyc_end (cyc_end)
    );

    // ----------------------------------------
    // Bus input synchroniser
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (i_rst) begin
            bus_m_q <= 8'h00;
            bus_s_q <= 8'h00;
        end else begin
            bus_m_q <= i_data_bus;
            bus_s_q <= bus_m_q;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    always @* begin
        sp_dec   = o_status_high_byte[`CLSR_SP_HI:`CLSR_SP_LO] - 3'h1;
        sp_inc   = o_status_high_byte[`CLSR_SP_HI:`CLSR_SP_LO] + 3'h1;
        ind_addr = {i_ins_byte1[6:0], i_ins_byte2} + {7'h00, gpr[i_ins_byte0[1:0]]};
        // Displacement is 7-bit signed, relative to the following byte
        rel_addr = i_ins_addr + 15'h0002 + {{8{i_ins_byte1[6]}}, i_ins_byte1[6:0]};
        ld_val   = bus_s_q;
        dst      = b0_q[1:0];
        if (ld_val[7])
            cc_new = `CLSR_CC_NEG;
        else if (ld_val == 8'h00)
            cc_new = `CLSR_CC_ZERO;
        else
            cc_new = `CLSR_CC_POS;
    end

    always @* begin
        o_reg0 = gpr[0];
        o_reg1 = gpr[1];
        o_reg2 = gpr[2];
        o_reg3 = gpr[3];
    end

    // ----------------------------------------
    // Execution sequencer
    // ----------------------------------------
    // Bus-driven instructions hold the strobes for their whole duration and
    // capture the synchronised bus on the final cycle edge, so two flops of
    // pin latency are absorbed inside the cycle.
    always @(posedge i_clock) begin
        if (i_rst) begin
            state_q                        <= S_IDLE;
            cyc_q                          <= 3'h0;
            b0_q                           <= 8'h00;
            b1_q                           <= 8'h00;
            next_q                         <= 15'h0000;
            o_busy                         <= 1'b0;
            o_operation_request            <= 1'b0;
            o_mem_io_n                     <= 1'b0;
            o_read_n_write                 <= 1'b0;
            o_data_n_ctrl                  <= 1'b0;
            o_extended_select              <= 1'b0;
            o_addr_bus                     <= 15'h0000;
            o_instruction_address_register <= 15'h0000;
            o_status_low_byte              <= 8'h00;
            o_status_high_byte             <= 8'h00;
            for (k = 0; k < 8; k = k + 1)
                ras_q[k] <= 15'h0000;
            for (k = 0; k < 4; k = k + 1)
                gpr[k] <= 8'h00;
        end else begin
            case (state_q)
            S_IDLE: begin
                if (cyc_end && i_int_req && !o_status_high_byte[`CLSR_II_BIT]) begin
                    ras_q[sp_inc]                                        <= i_ins_addr;
                    o_status_high_byte[`CLSR_SP_HI:`CLSR_SP_LO]          <= sp_inc;
                    o_status_high_byte[`CLSR_II_BIT]                     <= 1'b1;
                    o_instruction_address_register                       <= i_int_vector;
                end else if (cyc_end && i_ins_valid) begin
                    b0_q   <= i_ins_byte0;
                    b1_q   <= i_ins_byte1;
                    o_busy <= 1'b1;
                    state_q <= S_WAIT;
                    cyc_q  <= `CLSR_CYC_ONE - 3'h1;
                    next_q <= i_ins_addr + 15'h0001;
                    case (i_ins_byte0[7:2])
                    `CLSR_OP_LD_ABS: begin
                        state_q             <= S_BUS;
                        cyc_q               <= `CLSR_CYC_ABS - 3'h1;
                        next_q              <= i_ins_addr + 15'h0003;
                        o_operation_request <= 1'b1;
                        o_mem_io_n          <= 1'b1;
                        o_read_n_write      <= 1'b0;
                        o_extended_select   <= 1'b0;
                        o_addr_bus          <= i_ins_byte1[7] ? ind_addr :
                                               {i_ins_byte1[6:0], i_ins_byte2};
                    end
                    `CLSR_OP_LD_REL: begin
                        state_q             <= S_BUS;
                        cyc_q               <= `CLSR_CYC_REL - 3'h1;
                        next_q              <= i_ins_addr + 15'h0002;
                        o_operation_request <= 1'b1;
                        o_mem_io_n          <= 1'b1;
                        o_read_n_write      <= 1'b0;
                        o_extended_select   <= 1'b0;
                        o_addr_bus          <= rel_addr;
                    end
                    `CLSR_OP_RD_CTRL, `CLSR_OP_RD_DATA: begin
                        state_q             <= S_BUS;
                        cyc_q               <= `CLSR_CYC_RDPORT - 3'h1;
                        o_operation_request <= 1'b1;
                        o_mem_io_n          <= 1'b0;
                        o_read_n_write      <= 1'b0;
                        o_data_n_ctrl       <= i_ins_byte0[6];
                        o_extended_select   <= 1'b0;
                    end
                    `CLSR_OP_RD_EXT: begin
                        state_q             <= S_BUS;
                        cyc_q               <= `CLSR_CYC_RDEXT - 3'h1;
                        next_q              <= i_ins_addr + 15'h0002;
                        o_operation_request <= 1'b1;
                        o_mem_io_n          <= 1'b0;
                        o_read_n_write      <= 1'b0;
                        o_extended_select   <= 1'b1;
                        o_addr_bus          <= {7'h00, i_ins_byte1};
                    end
                    `CLSR_OP_LD_IMM: begin
                        cyc_q  <= `CLSR_CYC_IMM - 3'h1;
                        next_q <= i_ins_addr + 15'h0002;
                    end
                    `CLSR_OP_RET_COND, `CLSR_OP_RET_EN: begin
                        cyc_q <= `CLSR_CYC_RET - 3'h1;
                    end
                    default: begin
                        // Presets carry a mask byte and take an extra cycle
                        if (i_ins_byte0 == `CLSR_BY_PRE_ST_LOW || i_ins_byte0 == `CLSR_BY_PRE_ST_HIGH) begin
                            cyc_q  <= `CLSR_CYC_PRESET - 3'h1;
                            next_q <= i_ins_addr + 15'h0002;
                        end
                    end
                    endcase
                end
            end
            S_BUS: begin
                if (cyc_end) begin
                    // Count reaches zero on the last of the N cycles after the take edge
                    if (cyc_q == 3'h0) begin
                        o_operation_request <= 1'b0;
                        // Indexed absolute load always lands in register zero
                        if (b0_q[7:2] == `CLSR_OP_LD_ABS && b1_q[7])
                            gpr[0] <= ld_val;
                        else
                            gpr[dst] <= ld_val;
                        o_status_low_byte[`CLSR_CC_HI:`CLSR_CC_LO] <= cc_new;
                        o_instruction_address_register <= next_q;
                        o_busy  <= 1'b0;
                        state_q <= S_IDLE;
                    end
                    cyc_q <= cyc_q - 3'h1;
                end
            end
            S_WAIT: begin
                if (cyc_end) begin
                    cyc_q <= cyc_q - 3'h1;
                    if (cyc_q == 3'h0) begin
                        o_busy  <= 1'b0;
                        state_q <= S_IDLE;
                        o_instruction_address_register <= next_q;
                        case (b0_q[7:2])
                        `CLSR_OP_LD_IMM: begin
                            gpr[dst] <= b1_q;
                            o_status_low_byte[`CLSR_CC_HI:`CLSR_CC_LO] <=
                                b1_q[7] ? `CLSR_CC_NEG : (b1_q == 8'h00 ? `CLSR_CC_ZERO : `CLSR_CC_POS);
                        end
                        `CLSR_OP_LD_ZERO: begin
                            // All-zero opcode is undefined; it behaves as a copy of r0
                            gpr[0] <= gpr[dst];
                            o_status_low_byte[`CLSR_CC_HI:`CLSR_CC_LO] <=
                                gpr[dst][7] ? `CLSR_CC_NEG :
                                (gpr[dst] == 8'h00 ? `CLSR_CC_ZERO : `CLSR_CC_POS);
                        end
                        `CLSR_OP_RET_COND, `CLSR_OP_RET_EN: begin
                            if (dst == `CLSR_COND_ALWAYS ||
                                dst == o_status_low_byte[`CLSR_CC_HI:`CLSR_CC_LO]) begin
                                o_instruction_address_register <= ras_q[o_status_high_byte[`CLSR_SP_HI:`CLSR_SP_LO]];
                                o_status_high_byte[`CLSR_SP_HI:`CLSR_SP_LO] <= sp_dec;
                                if (b0_q[5])
                                    o_status_high_byte[`CLSR_II_BIT] <= 1'b0;
                            end
                        end
                        default: begin
                            if (b0_q == `CLSR_BY_LD_ST_LOW)
                                o_status_low_byte <= gpr[0];
                            else if (b0_q == `CLSR_BY_LD_ST_HIGH)
                                o_status_high_byte <= gpr[0] & `CLSR_HIGH_MASK;
                            else if (b0_q == `CLSR_BY_PRE_ST_LOW)
                                o_status_low_byte <= o_status_low_byte | b1_q;
                            else if (b0_q == `CLSR_BY_PRE_ST_HIGH)
                                o_status_high_byte <= (o_status_high_byte | b1_q) & `CLSR_HIGH_MASK;
                            // No-operation and anything else falls through untouched
                        end
                        endcase
                    end
                end
            end
            default: begin
                state_q <= S_IDLE;
            end
            endcase
        end
    end
endmodule // clsr_exec

`default_nettype wire

// ### src/clsr_defs.vh
// Purpose: Constants for the load/status/port-read/return execution block
// Assumes: 8-bit data, 15-bit address, three clocks per processor cycle
// Notes:   Included by bare name
`ifndef CLSR_DEFS_VH
`define CLSR_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLSR_CLK_PER_CYC      2'h3
`define CLSR_CYC_ABS          3'h4
`define CLSR_CYC_IMM          3'h2
`define CLSR_CYC_REL          3'h3
`define CLSR_CYC_ONE          3'h2
`define CLSR_CYC_PRESET       3'h3
`define CLSR_CYC_RDPORT       3'h2
`define CLSR_CYC_RDEXT        3'h3
`define CLSR_CYC_RET          3'h3

// ----------------------------------------
// Opcodes (upper six bits)
// ----------------------------------------
`define CLSR_OP_LD_ZERO       6'h00
`define CLSR_OP_LD_IMM        6'h01
`define CLSR_OP_LD_REL        6'h02
`define CLSR_OP_LD_ABS        6'h03
`define CLSR_OP_RET_COND      6'h05
`define CLSR_OP_RD_CTRL       6'h0C
`define CLSR_OP_RET_EN        6'h0D
`define CLSR_OP_RD_DATA       6'h1C
`define CLSR_OP_RD_EXT        6'h15
`define CLSR_OP_STATUS        6'h24
`define CLSR_OP_PRESET        6'h1D
`define CLSR_OP_NOP           6'h30

// Full-byte opcodes for the status group
`define CLSR_BY_LD_ST_HIGH    8'h92
`define CLSR_BY_LD_ST_LOW     8'h93
`define CLSR_BY_PRE_ST_HIGH   8'h76
`define CLSR_BY_PRE_ST_LOW    8'h77

// ----------------------------------------
// Status fields
// ----------------------------------------
`define CLSR_CC_HI            7
`define CLSR_CC_LO            6
`define CLSR_II_BIT           5
`define CLSR_SP_HI            2
`define CLSR_SP_LO            0
`define CLSR_HIGH_MASK        8'hE7
`define CLSR_CC_POS           2'h1
`define CLSR_CC_ZERO          2'h0
`define CLSR_CC_NEG           2'h2
`define CLSR_COND_ALWAYS      2'h3

`endif

// ### src/clsr_phase.v
// Purpose: Divides the clock into three-period processor cycles
// Assumes: Single clock, synchronous reset
// Notes:   o_cyc_end pulses on the last clock of each cycle
`timescale 1ns/1ns
`default_nettype none
`include "clsr_defs.vh"

module clsr_phase (
    input  wire       i_clock,
    input  wire       i_rst,
    output reg        o_cyc_end
);
    reg [1:0] cnt_q;

    // ----------------------------------------
    // Phase counter
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (i_rst) begin
            cnt_q     <= 2'h0;
            o_cyc_end <= 1'b0;
        end else begin
            cnt_q     <= (cnt_q == `CLSR_CLK_PER_CYC - 2'h1) ? 2'h0 : cnt_q + 2'h1;
            o_cyc_end <= (cnt_q == `CLSR_CLK_PER_CYC - 2'h2);
        end
    end
endmodule // clsr_phase

`default_nettype wire

// ### verification/clsr_exec_checker.sv
// Purpose: Port-level timing and strobe checks for clsr_exec
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module clsr_exec_checker (
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_int_req,
    input wire logic       o_busy,
    input wire logic       o_operation_request,
    input wire logic       o_mem_io_n,
    input wire logic       o_read_n_write,
    input wire logic       o_data_n_ctrl,
    input wire logic       o_extended_select,
    input wire logic [7:0] o_status_low_byte,
    input wire logic [7:0] o_status_high_byte,
    input wire logic [7:0] o_reg0,
    input wire logic [7:0] o_reg1,
    input wire logic [7:0] o_reg2,
    input wire logic [7:0] o_reg3
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Busy length counter
    // ----------------------------------------
    logic [4:0] busy_cnt_q;
    logic [4:0] busy_cnt_d;
    assign busy_cnt_d = o_busy ? busy_cnt_q + 5'h1 : 5'h0;
    always_ff @(posedge i_clock) begin
        if (i_rst)
            busy_cnt_q <= 5'h0;
        else
            busy_cnt_q <= busy_cnt_d;
    end
    sequence s_port_start;
        $rose(o_operation_request) && !o_mem_io_n && !o_extended_select;
    endsequence
    sequence s_hold_two_cyc;
        o_operation_request[*6] ##1 !o_operation_request;
    endsequence
    sequence s_hold_three_cyc;
        o_operation_request[*8] ##1 o_operation_request ##1 !o_operation_request;
    endsequence
    a_read_only: assert property (o_operation_request |-> !o_read_n_write)
        else $error("Bus request is not a read");
    a_req_in_busy: assert property (o_operation_request |-> o_busy)
        else $error("Bus request outside an instruction");
    a_ext_is_io: assert property (o_operation_request && o_extended_select |-> !o_mem_io_n)
        else $error("Extended read not marked as IO");
    a_high_gaps: assert property (o_status_high_byte[4:3] == 2'h0)
        else $error("Unassigned high status bits not zero");
    a_strobes_stand: assert property (o_operation_request && $past(o_operation_request)
        |-> $stable({o_mem_io_n, o_data_n_ctrl, o_extended_select}))
        else $error("Bus qualifiers changed during request");
    a_busy_length: assert property ($fell(o_busy)
        |-> busy_cnt_q >= 5'h6 && busy_cnt_q % 5'h3 == 5'h0)
        else $error("Instruction length not whole processor cycles");
    // An accepted interrupt updates the high status byte without raising busy
    a_idle_quiet: assert property (!o_busy && !$past(o_busy) && !$past(i_rst) && !$past(i_int_req)
        |-> $stable({o_reg0, o_reg1,
        o_reg2, o_reg3, o_status_low_byte, o_status_high_byte}))
        else $error("State changed while idle");
    a_port_length: assert property (s_port_start |-> s_hold_two_cyc)
        else $error("Port read request not two cycles");
    a_ext_length: assert property ($rose(o_operation_request) && o_extended_select
        |-> s_hold_three_cyc)
        else $error("Extended read request not three cycles");
endmodule // clsr_exec_checker
bind clsr_exec clsr_exec_checker clsr_exec_checker_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_int_req(i_int_req), .o_busy(o_busy),
    .o_operation_request(o_operation_request),
    .o_mem_io_n(o_mem_io_n), .o_read_n_write(o_read_n_write), .o_data_n_ctrl(o_data_n_ctrl),
    .o_extended_select(o_extended_select), .o_status_low_byte(o_status_low_byte),
    .o_status_high_byte(o_status_high_byte), .o_reg0(o_reg0), .o_reg1(o_reg1), .o_reg2(o_reg2), .o_reg3(o_reg3)
);
`default_nettype wire

// ### verification/clsr_bus_model.sv
// Purpose: Memory and port devices on the processor bus
// Assumes: Memory byte is a fixed function of its address
// Notes:   Bus has no pull resistor, so a released bus toggles
`timescale 1ns/1ns
`default_nettype none
module clsr_bus_model (
    input  wire logic        i_clock,
    input  wire logic        i_operation_request,
    input  wire logic        i_mem_io_n,
    input  wire logic        i_data_n_ctrl,
    input  wire logic        i_extended_select,
    input  wire logic [14:0] i_addr_bus,
    output var  logic [7:0]  o_data_bus
);
    parameter logic [7:0] CTRL_PORT = 8'hC3;
    parameter logic [7:0] DATA_PORT = 8'h3C;
    initial o_data_bus = 8'h00;
    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always @(posedge i_clock) begin
        if (!i_operation_request)
            o_data_bus <= ~o_data_bus;
        else if (i_mem_io_n)
            o_data_bus <= i_addr_bus[7:0] ^ {1'b0, i_addr_bus[14:8]} ^ 8'h5A;
        else if (i_extended_select)
            o_data_bus <= i_addr_bus[7:0] ^ 8'hA5;
        else if (i_data_n_ctrl)
            o_data_bus <= DATA_PORT;
        else
            o_data_bus <= CTRL_PORT;
    end
endmodule // clsr_bus_model
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for clsr_exec
// Assumes: Instruction address fixed at 0200, vector at 1234
// Notes:   Register values chain from one step to the next
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        i_clock;
    logic        i_rst;
    logic        i_ins_valid;
    logic        i_int_req;
    logic [7:0]  b0_q, b1_q, b2_q, dbus, status_low_byte, status_high_byte, r0, r1, r2, r3;
    logic        busy, req, mio, rnw, dnc, ext;
    logic [14:0] addr, instruction_address_register;
    logic [15:0] snap;
    int          err_total = 0;
    int          checks_done = 0;
    clsr_exec clsr_exec_i (.i_clock(i_clock), .i_rst(i_rst), .i_ins_valid(i_ins_valid), .i_ins_byte0(b0_q),
        .i_ins_byte1(b1_q), .i_ins_byte2(b2_q), .i_ins_addr(15'h0200), .i_int_req(i_int_req),
        .i_int_vector(15'h1234), .i_data_bus(dbus), .o_busy(busy), .o_operation_request(req),
        .o_mem_io_n(mio), .o_read_n_write(rnw), .o_data_n_ctrl(dnc), .o_extended_select(ext),
        .o_addr_bus(addr), .o_instruction_address_register(instruction_address_register), .o_status_low_byte(status_low_byte),
        .o_status_high_byte(status_high_byte), .o_reg0(r0), .o_reg1(r1), .o_reg2(r2), .o_reg3(r3));
    clsr_bus_model clsr_bus_model_i (.i_clock(i_clock), .i_operation_request(req), .i_mem_io_n(mio),
        .i_data_n_ctrl(dnc), .i_extended_select(ext), .i_addr_bus(addr), .o_data_bus(dbus));
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] rsel(input int ri);
        case (ri)
            0: return r0;
            1: return r1;
            2: return r2;
            default: return r3;
        endcase
    endfunction
    // ----------------------------------------
    // One instruction; n = 0 raises an interrupt instead
    // ----------------------------------------
    task automatic op(input logic [7:0] b0, b1, b2, input int n, input int ri, input logic [7:0] ev);
        int c;
        c = 0;
        @(posedge i_clock);
        b0_q <= b0;
        b1_q <= b1;
        b2_q <= b2;
        if (n == 0) i_int_req <= 1'b1;
        else i_ins_valid <= 1'b1;
        // An accepted interrupt never raises busy; drop the request after four clocks, over one full cycle
        if (n == 0) begin
            repeat (4) @(posedge i_clock);
            i_int_req <= 1'b0;
        end
        while (n != 0 && !busy && c < 20) begin
            @(posedge i_clock);
            #1;
            c++;
        end
        if (n != 0) chk("started", 16'h0001, {15'h0000, busy});
        c = 0;
        while (busy && c < 60) begin
            @(posedge i_clock);
            i_ins_valid <= 1'b0;
            i_int_req <= 1'b0;
            #1;
            c++;
        end
        if (n != 0) chk("cycles", 16'(n * 3), 16'(c));
        if (ri < 4) begin
            chk("register", {8'h00, ev}, {8'h00, rsel(ri)});
            chk("cc", {14'h0, ev == 8'h00 ? 2'h0 : ev[7] ? 2'h2 : 2'h1}, {14'h0, status_low_byte[7:6]});
        end
        $display("Step done, opcode %h", b0);
    endtask
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        i_ins_valid = 1'b0;
        i_int_req = 1'b0;
        {b0_q, b1_q, b2_q} = 24'h000000;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        chk("reset state", 16'h0000, {7'h00, busy, status_high_byte | status_low_byte | r0 | r3});
        op(8'h05, 8'h85, 8'h00, 2, 1, 8'h85);
        op(8'h06, 8'h00, 8'h00, 2, 2, 8'h00);
        op(8'h07, 8'h7F, 8'h00, 2, 3, 8'h7F);
        op(8'h01, 8'h00, 8'h00, 2, 0, 8'h85);
        chk("source kept", 16'h0085, {8'h00, r1});
        op(8'h0E, 8'h01, 8'h23, 4, 2, 8'h78);
        op(8'h0F, 8'h81, 8'h23, 4, 0, 8'hF9);
        op(8'h09, 8'h7E, 8'h00, 3, 1, 8'h58);
        op(8'h32, 8'h00, 8'h00, 2, 2, 8'hC3);
        op(8'h73, 8'h00, 8'h00, 2, 3, 8'h3C);
        op(8'h54, 8'h81, 8'h00, 3, 0, 8'h24);
        snap = {r0, r1};
        op(8'hC0, 8'h00, 8'h00, 2, 4, 8'h00);
        chk("nop regs", snap, {r0, r1});
        chk("nop status", 16'h4000, {status_low_byte, status_high_byte});
        op(8'h00, 8'h00, 8'h00, 0, 4, 8'h00);
        chk("vector", 16'h1234, {1'b0, instruction_address_register});
        chk("high status", 16'h0021, {8'h00, status_high_byte});
        op(8'h07, 8'h7F, 8'h00, 2, 3, 8'h7F);
        op(8'h16, 8'h00, 8'h00, 3, 4, 8'h00);
        chk("high status", 16'h0021, {8'h00, status_high_byte});
        chk("next address", 16'h0201, {1'b0, instruction_address_register});
        op(8'h35, 8'h00, 8'h00, 3, 4, 8'h00);
        chk("high status", 16'h0000, {8'h00, status_high_byte});
        chk("return address", 16'h0200, {1'b0, instruction_address_register});
        op(8'h00, 8'h00, 8'h00, 0, 4, 8'h00);
        op(8'h06, 8'h00, 8'h00, 2, 2, 8'h00);
        op(8'h36, 8'h00, 8'h00, 3, 4, 8'h00);
        chk("high status", 16'h0021, {8'h00, status_high_byte});
        op(8'h17, 8'h00, 8'h00, 3, 4, 8'h00);
        chk("high status", 16'h0020, {8'h00, status_high_byte});
        op(8'h04, 8'hF5, 8'h00, 2, 0, 8'hF5);
        op(8'h93, 8'h00, 8'h00, 2, 4, 8'h00);
        chk("low status", 16'h00F5, {8'h00, status_low_byte});
        op(8'h92, 8'h00, 8'h00, 2, 4, 8'h00);
        chk("high status", 16'h00E5, {8'h00, status_high_byte});
        op(8'h04, 8'h00, 8'h00, 2, 0, 8'h00);
        op(8'h77, 8'h0A, 8'h00, 3, 4, 8'h00);
        chk("low status", 16'h003F, {8'h00, status_low_byte});
        op(8'h76, 8'h02, 8'h00, 3, 4, 8'h00);
        chk("high status", 16'h00E7, {8'h00, status_high_byte});
        stop_test();
    end
endmodule // tb
`default_nettype wire
